// ### hdl/tlb_slot_bridge.sv
// backplane to local serial bus slot bridge with apb registers
// What this block does
// - frame sync code 00 low half bit straddling boundary (last half bit when direct), 11 high full bit before.
// - sample code 00 at 4/4, 01 at 3/4 (2/4 when direct), 10 at 2/4 of each bit.
// - local bit clock from backplane clock, direct, divided by 2 or by 4.
// - four-bit field picks backplane input stream feeding local output.
// - four-bit field picks backplane output stream fed from local input.
// - seven-bit start slot goes into local output slot zero.
// - outbound slot count is field plus one, one to thirty-two.
// - outbound transfer runs only while its enable bit is one.
// - local input loops to local output whenever outbound transfer is idle.
// - both directions need the global memory transfer enable set.
// - local input slot zero goes into the seven-bit backplane slot.
// - inbound slot count is field plus one, one to thirty-two.
// - enabled inbound slots replace reassembly data on the backplane output.
// - backplane speed gives 32, 64 or 128 slots per frame.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tlb_slot_bridge #(
   parameter int SLOT_W = 7,
   parameter int STREAM_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tlb_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bp_frame_start,
   input wire logic bp_slot_tick,
   input wire logic [SLOT_W-1:0] bp_slot_num,
   input wire logic [7:0] bp_src_byte,
   output logic [STREAM_W-1:0] bp_src_stream,
   output logic [STREAM_W-1:0] bp_dst_stream,
   output logic [SLOT_W-1:0] bp_dst_slot,
   output logic [7:0] bp_dst_byte,
   output logic bp_dst_valid,
   input wire logic local_serial_in,
   output logic local_serial_out,
   output logic local_bit_clock,
   output logic local_frame_sync
);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (SLOT_W != 7) begin : g_bad_slot_w
      $error("slot field width must be 7");
   end
   if (STREAM_W != 4) begin : g_bad_stream_w
      $error("stream field width must be 4");
   end

   // ****************************************************************
   // registers and decoded fields
   // ****************************************************************
   logic [15:0] global_ctrl_r;
   logic [15:0] local_bus_format_r;
   logic [15:0] backplane_to_local_r;
   logic [15:0] local_to_backplane_r;
   logic [15:0] status;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic memory_transfer_enable;
   logic [1:0] backplane_speed_sel;
   logic [1:0] local_frame_sync_format;
   logic [1:0] local_sample_point;
   logic [1:0] local_clock_divider;
   logic [STREAM_W-1:0] backplane_source_stream_sel;
   logic [STREAM_W-1:0] backplane_dest_stream_sel;
   logic [SLOT_W-1:0] outbound_start_slot;
   logic [6:0] outbound_slot_count;
   logic outbound_transfer_enable;
   logic [SLOT_W-1:0] inbound_start_slot;
   logic [6:0] inbound_slot_count;
   logic inbound_transfer_enable;

   assign memory_transfer_enable = global_ctrl_r[tlb_pkg::GC_MEM_EN_BIT];
   assign backplane_speed_sel =
      global_ctrl_r[tlb_pkg::GC_SPEED_LSB +: 2];
   assign local_frame_sync_format =
      local_bus_format_r[tlb_pkg::LBF_FSYNC_LSB +: 2];
   assign local_sample_point =
      local_bus_format_r[tlb_pkg::LBF_SAMPLE_LSB +: 2];
   assign local_clock_divider =
      local_bus_format_r[tlb_pkg::LBF_DIV_LSB +: 2];
   assign backplane_source_stream_sel =
      local_bus_format_r[tlb_pkg::LBF_SRC_STREAM_LSB +: STREAM_W];
   assign backplane_dest_stream_sel =
      local_bus_format_r[tlb_pkg::LBF_DST_STREAM_LSB +: STREAM_W];
   assign outbound_start_slot =
      backplane_to_local_r[tlb_pkg::XFR_START_LSB +: SLOT_W];
   assign outbound_slot_count =
      backplane_to_local_r[tlb_pkg::XFR_COUNT_LSB +: 7];
   assign outbound_transfer_enable =
      backplane_to_local_r[tlb_pkg::XFR_ENABLE_BIT];
   assign inbound_start_slot =
      local_to_backplane_r[tlb_pkg::XFR_START_LSB +: SLOT_W];
   assign inbound_slot_count =
      local_to_backplane_r[tlb_pkg::XFR_COUNT_LSB +: 7];
   assign inbound_transfer_enable =
      local_to_backplane_r[tlb_pkg::XFR_ENABLE_BIT];

   // ****************************************************************
   // apb slave: zero wait states, error on unmapped address
   // ****************************************************************
   logic setup;
   logic access;
   logic mapped;
   logic [15:0] wmask;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign mapped = (paddr == tlb_pkg::ADDR_GLOBAL_CTRL) ||
      (paddr == tlb_pkg::ADDR_LOCAL_BUS_FORMAT) ||
      (paddr == tlb_pkg::ADDR_BACKPLANE_TO_LOCAL) ||
      (paddr == tlb_pkg::ADDR_LOCAL_TO_BACKPLANE) ||
      (paddr == tlb_pkg::ADDR_BRIDGE_STATUS);
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] wd, input logic [15:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_ctrl_r <= tlb_pkg::RST_GLOBAL_CTRL;
         local_bus_format_r <= tlb_pkg::RST_LOCAL_BUS_FORMAT;
         backplane_to_local_r <= tlb_pkg::RST_BACKPLANE_TO_LOCAL;
         local_to_backplane_r <= tlb_pkg::RST_LOCAL_TO_BACKPLANE;
      end else if (access && pwrite) begin
         unique case (paddr)
            tlb_pkg::ADDR_GLOBAL_CTRL: global_ctrl_r <=
               merge(global_ctrl_r, pwdata[15:0], wmask);
            tlb_pkg::ADDR_LOCAL_BUS_FORMAT: local_bus_format_r <=
               merge(local_bus_format_r, pwdata[15:0], wmask);
            tlb_pkg::ADDR_BACKPLANE_TO_LOCAL: backplane_to_local_r <=
               merge(backplane_to_local_r, pwdata[15:0], wmask);
            tlb_pkg::ADDR_LOCAL_TO_BACKPLANE: local_to_backplane_r <=
               merge(local_to_backplane_r, pwdata[15:0], wmask);
            default: ;
         endcase
      end
   end

   // read data and error prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         pslverr_r <= !mapped;
         unique case (paddr)
            tlb_pkg::ADDR_GLOBAL_CTRL: prdata_r <= {16'h0000, global_ctrl_r};
            tlb_pkg::ADDR_LOCAL_BUS_FORMAT:
               prdata_r <= {16'h0000, local_bus_format_r};
            tlb_pkg::ADDR_BACKPLANE_TO_LOCAL:
               prdata_r <= {16'h0000, backplane_to_local_r};
            tlb_pkg::ADDR_LOCAL_TO_BACKPLANE:
               prdata_r <= {16'h0000, local_to_backplane_r};
            tlb_pkg::ADDR_BRIDGE_STATUS: prdata_r <= {16'h0000, status};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r && access;
   assign pready = 1'b1;

   // ****************************************************************
   // local input synchroniser: change taken when stages two and three agree
   // ****************************************************************
   logic [tlb_pkg::IN_SYNC_STAGES-1:0] in_sync_r;
   logic in_filt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sync_r <= '0;
         in_filt_r <= 1'b0;
      end else begin
         in_sync_r <= {in_sync_r[1:0], local_serial_in};
         if (in_sync_r[1] == in_sync_r[2]) begin
            in_filt_r <= in_sync_r[2];
         end
      end
   end

   // ****************************************************************
   // local bit timing
   // ****************************************************************
   logic bit_start;
   logic sample_tick;
   logic [7:0] bit_idx;
   logic [4:0] local_slot;
   logic [2:0] local_bit;

   tlb_bit_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .frame_start(bp_frame_start),
      .div_code(local_clock_divider),
      .fsync_fmt(local_frame_sync_format),
      .sample_code(local_sample_point),
      .bit_start(bit_start),
      .sample_tick(sample_tick),
      .bit_idx(bit_idx),
      .bit_clk(local_bit_clock),
      .fsync(local_frame_sync)
   );

   assign local_slot = bit_idx[7:3];
   assign local_bit = bit_idx[2:0];

   // ****************************************************************
   // backplane slot offsets, wrapped to the frame length
   // ****************************************************************
   logic [SLOT_W-1:0] slot_mask;
   logic [SLOT_W-1:0] out_off;
   logic [SLOT_W-1:0] in_off;
   logic [6:0] out_cnt;
   logic [6:0] in_cnt;
   logic out_run;
   logic in_run;

   always_comb begin
      unique case (backplane_speed_sel)
         tlb_pkg::SPEED_2M: slot_mask = 7'h1f;
         tlb_pkg::SPEED_4M: slot_mask = 7'h3f;
         default: slot_mask = 7'h7f;
      endcase
   end

   assign out_off = (bp_slot_num - outbound_start_slot) & slot_mask;
   assign in_off = (bp_slot_num - inbound_start_slot) & slot_mask;
   // count fields above thirty-one clamp to thirty-two
   assign out_cnt = (outbound_slot_count > 7'h1f) ? 7'h20 :
      outbound_slot_count + 7'h01;
   assign in_cnt = (inbound_slot_count > 7'h1f) ? 7'h20 :
      inbound_slot_count + 7'h01;
   assign out_run = memory_transfer_enable && outbound_transfer_enable;
   assign in_run = memory_transfer_enable && inbound_transfer_enable;

   // ****************************************************************
   // frame banks: one side fills while the other side drains
   // ****************************************************************
   logic bank_r;
   logic [7:0] out_buf [0:2*tlb_pkg::LOCAL_SLOTS-1];
   logic [7:0] in_buf [0:2*tlb_pkg::LOCAL_SLOTS-1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_r <= 1'b0;
      end else if (bp_frame_start) begin
         bank_r <= !bank_r;
      end
   end

   assign bp_src_stream = backplane_source_stream_sel;

   // outbound capture from the selected backplane input stream
   always_ff @(posedge pclk) begin
      if (bp_slot_tick && out_run && ({1'b0, out_off} < {1'b0, out_cnt})) begin
         out_buf[{bank_r, out_off[4:0]}] <= bp_src_byte;
      end
   end

   // ****************************************************************
   // local serial output: slot data or loopback
   // ****************************************************************
   logic out_slot_live;
   logic [7:0] out_byte;
   logic out_r;

   assign out_slot_live = out_run && ({2'b00, local_slot} < out_cnt);
   assign out_byte = out_buf[{!bank_r, local_slot}];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= 1'b0;
      end else if (!out_slot_live) begin
         out_r <= in_filt_r;
      end else if (bit_start) begin
         out_r <= out_byte[3'h7 - local_bit];
      end
   end

   assign local_serial_out = out_r;

   // ****************************************************************
   // local serial input: assemble bytes at the sample point
   // ****************************************************************
   logic [6:0] in_shift_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_shift_r <= 7'h00;
      end else if (sample_tick) begin
         in_shift_r <= {in_shift_r[5:0], in_filt_r};
      end
   end

   always_ff @(posedge pclk) begin
      if (sample_tick && (local_bit == 3'h7) &&
         ({2'b00, local_slot} < in_cnt)) begin
         in_buf[{bank_r, local_slot}] <= {in_shift_r, in_filt_r};
      end
   end

   // ****************************************************************
   // backplane output: replaces reassembly data in the chosen slots
   // ****************************************************************
   logic [STREAM_W-1:0] dst_stream_r;
   logic [SLOT_W-1:0] dst_slot_r;
   logic [7:0] dst_byte_r;
   logic dst_valid_r;
   logic in_hit;

   assign in_hit = bp_slot_tick && in_run &&
      ({1'b0, in_off} < {1'b0, in_cnt});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dst_stream_r <= '0;
         dst_slot_r <= '0;
         dst_byte_r <= 8'h00;
         dst_valid_r <= 1'b0;
      end else begin
         dst_valid_r <= in_hit;
         if (bp_slot_tick) begin
            dst_stream_r <= backplane_dest_stream_sel;
            dst_slot_r <= bp_slot_num;
         end
         if (in_hit) begin
            dst_byte_r <= in_buf[{!bank_r, in_off[4:0]}];
         end
      end
   end

   assign bp_dst_stream = dst_stream_r;
   assign bp_dst_slot = dst_slot_r;
   assign bp_dst_byte = dst_byte_r;
   assign bp_dst_valid = dst_valid_r;

   // ****************************************************************
   // status: loopback state and local position
   // ****************************************************************
   assign status = {bit_idx, 5'h00, in_run, out_run, !out_slot_live};
endmodule : tlb_slot_bridge
`default_nettype wire

// ### hdl/tlb_pkg.sv
// package: register map, field layout and timing constants of the slot bridge
package tlb_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam logic [15:0] IDX_GLOBAL_CTRL = 16'h6000;
   localparam logic [15:0] IDX_LOCAL_BUS_FORMAT = 16'h6020;
   localparam logic [15:0] IDX_BACKPLANE_TO_LOCAL = 16'h6022;
   localparam logic [15:0] IDX_LOCAL_TO_BACKPLANE = 16'h6024;
   localparam logic [15:0] IDX_BRIDGE_STATUS = 16'h6026;
   localparam int ADDR_W = 18;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CTRL = {IDX_GLOBAL_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_LOCAL_BUS_FORMAT =
      {IDX_LOCAL_BUS_FORMAT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_BACKPLANE_TO_LOCAL =
      {IDX_BACKPLANE_TO_LOCAL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_LOCAL_TO_BACKPLANE =
      {IDX_LOCAL_TO_BACKPLANE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_BRIDGE_STATUS =
      {IDX_BRIDGE_STATUS, 2'b00};

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] RST_GLOBAL_CTRL = 16'h0000;
   localparam logic [15:0] RST_LOCAL_BUS_FORMAT = 16'h0000;
   localparam logic [15:0] RST_BACKPLANE_TO_LOCAL = 16'h0000;
   localparam logic [15:0] RST_LOCAL_TO_BACKPLANE = 16'h0000;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int GC_MEM_EN_BIT = 0;
   localparam int GC_SPEED_LSB = 4;
   localparam int LBF_FSYNC_LSB = 0;
   localparam int LBF_SAMPLE_LSB = 2;
   localparam int LBF_DIV_LSB = 6;
   localparam int LBF_SRC_STREAM_LSB = 8;
   localparam int LBF_DST_STREAM_LSB = 12;
   localparam int XFR_START_LSB = 0;
   localparam int XFR_COUNT_LSB = 8;
   localparam int XFR_ENABLE_BIT = 15;

   // ****************************************************************
   // field codes
   // ****************************************************************
   localparam logic [1:0] FSYNC_LOW_HALF = 2'h0;
   localparam logic [1:0] FSYNC_HIGH_FULL = 2'h3;
   localparam logic [1:0] SAMPLE_4Q = 2'h0;
   localparam logic [1:0] SAMPLE_3Q = 2'h1;
   localparam logic [1:0] SAMPLE_2Q = 2'h2;
   localparam logic [1:0] DIV_DIRECT = 2'h0;
   localparam logic [1:0] DIV_BY_2 = 2'h1;
   localparam logic [1:0] DIV_BY_4 = 2'h2;
   localparam logic [1:0] SPEED_2M = 2'h0;
   localparam logic [1:0] SPEED_4M = 2'h1;
   localparam logic [1:0] SPEED_8M = 2'h2;

   // ****************************************************************
   // local frame geometry and clock timing
   // ****************************************************************
   localparam int LOCAL_SLOTS = 32;
   localparam int BITS_PER_SLOT = 8;
   localparam logic [7:0] LAST_LOCAL_BIT = 8'hff;
   localparam int CLK_PERIOD_NS = 8;
   localparam int IN_SYNC_STAGES = 3;
endpackage : tlb_pkg

// ### hdl/tlb_bit_timer.sv
// local bit clock, frame sync and sample point generator
`timescale 1ns/1ns
`default_nettype none
module tlb_bit_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic frame_start,
   input wire logic [1:0] div_code,
   input wire logic [1:0] fsync_fmt,
   input wire logic [1:0] sample_code,
   output logic bit_start,
   output logic sample_tick,
   output logic [7:0] bit_idx,
   output logic bit_clk,
   output logic fsync
);
   // ****************************************************************
   // bit period: two clocks per bit undivided
   // ****************************************************************
   logic [3:0] period;
   logic [3:0] half;
   logic [3:0] quarter;
   logic [3:0] samp_cyc;
   logic [3:0] cyc_r;
   logic [7:0] bit_r;
   logic clk_r;
   logic fs_r;

   always_comb begin
      unique case (div_code)
         tlb_pkg::DIV_DIRECT: period = 4'h2;
         tlb_pkg::DIV_BY_2: period = 4'h4;
         default: period = 4'h8;
      endcase
   end

   assign half = {1'b0, period[3:1]};
   assign quarter = {2'b00, period[3:2]};

   // sample position inside the bit
   always_comb begin
      unique case (sample_code)
         tlb_pkg::SAMPLE_3Q: samp_cyc = half + quarter;
         tlb_pkg::SAMPLE_2Q: samp_cyc = half;
         default: samp_cyc = period;
      endcase
      if (samp_cyc != 4'h0) begin
         samp_cyc = samp_cyc - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_r <= 4'h0;
         bit_r <= 8'h00;
      end else if (frame_start) begin
         cyc_r <= 4'h0;
         bit_r <= 8'h00;
      end else if (cyc_r >= period - 4'h1) begin
         cyc_r <= 4'h0;
         bit_r <= bit_r + 8'h01;
      end else begin
         cyc_r <= cyc_r + 4'h1;
      end
   end

   assign bit_start = (cyc_r == 4'h0);
   assign sample_tick = (cyc_r == samp_cyc);
   assign bit_idx = bit_r;

   // ****************************************************************
   // clock and frame sync, one clock behind the counters like the data
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_r <= 1'b0;
         fs_r <= 1'b1;
      end else begin
         clk_r <= (cyc_r < half);
         if (fsync_fmt == tlb_pkg::FSYNC_HIGH_FULL) begin
            fs_r <= (bit_r == tlb_pkg::LAST_LOCAL_BIT);
         end else begin
            fs_r <= !(((bit_r == tlb_pkg::LAST_LOCAL_BIT) &&
               (cyc_r >= half + quarter)) ||
               ((bit_r == 8'h00) && (cyc_r < quarter)));
         end
      end
   end

   assign bit_clk = clk_r;
   assign fsync = fs_r;
endmodule : tlb_bit_timer
`default_nettype wire

// ### verif/tlb_slot_bridge_checker.sv
// checker: port properties of the slot bridge
`timescale 1ns/1ns
`default_nettype none
module tlb_slot_bridge_checker #(
   parameter int SLOT_W = 7,
   parameter int STREAM_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tlb_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic bp_frame_start,
   input wire logic bp_slot_tick,
   input wire logic [SLOT_W-1:0] bp_slot_num,
   input wire logic [STREAM_W-1:0] bp_src_stream,
   input wire logic [SLOT_W-1:0] bp_dst_slot,
   input wire logic [7:0] bp_dst_byte,
   input wire logic bp_dst_valid,
   input wire logic local_bit_clock,
   input wire logic local_frame_sync
);
   // *****
   // helper state
   // *****
   logic [1:0] div_r;
   logic [1:0] fmt_r;
   logic settled_r;
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr inside {tlb_pkg::ADDR_GLOBAL_CTRL,
      tlb_pkg::ADDR_LOCAL_BUS_FORMAT, tlb_pkg::ADDR_BACKPLANE_TO_LOCAL,
      tlb_pkg::ADDR_LOCAL_TO_BACKPLANE, tlb_pkg::ADDR_BRIDGE_STATUS};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 2'h0;
         fmt_r <= 2'h0;
      end else if (acc && pwrite && pstrb[0]
            && paddr == tlb_pkg::ADDR_LOCAL_BUS_FORMAT) begin
         div_r <= pwdata[7:6];
         fmt_r <= pwdata[1:0];
      end
   end
   // timing checked only after a clean frame restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) settled_r <= 1'b0;
      else if (psel) settled_r <= 1'b0;
      else if (bp_frame_start) settled_r <= 1'b1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr_lbf;
      acc && pwrite && pstrb[1] && paddr == tlb_pkg::ADDR_LOCAL_BUS_FORMAT;
   endsequence
   sequence s_half_bit;
      local_bit_clock [*4];
   endsequence
   property p_ready;
      pready;
   endproperty
   property p_err_mapped;
      acc && mapped |-> !pslverr;
   endproperty
   property p_err_unmapped;
      acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   property p_hi_zero;
      prdata[31:16] == 16'h0;
   endproperty
   property p_src_stream;
      s_wr_lbf |=> bp_src_stream == $past(pwdata[11:8]);
   endproperty
   property p_valid_cause;
      bp_dst_valid |-> $past(bp_slot_tick) && bp_dst_slot == $past(bp_slot_num);
   endproperty
   property p_dst_hold;
      !$past(bp_slot_tick) |-> $stable(bp_dst_slot) && $stable(bp_dst_byte);
   endproperty
   property p_bit_clk;
      $rose(local_bit_clock) && settled_r && div_r == 2'h2
         |-> s_half_bit ##1 !local_bit_clock [*4];
   endproperty
   property p_fsync;
      $fell(local_frame_sync) && settled_r && fmt_r == 2'h0 && div_r == 2'h2
         |-> !local_frame_sync [*4] ##1 local_frame_sync;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_err_mapped: assert property (p_err_mapped) else $error("bad pslverr");
   a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
   a_hi_zero: assert property (p_hi_zero) else $error("prdata high bits");
   a_src_stream: assert property (p_src_stream) else $error("src stream");
   a_valid_cause: assert property (p_valid_cause) else $error("dst valid");
   a_dst_hold: assert property (p_dst_hold) else $error("dst not held");
   a_bit_clk: assert property (p_bit_clk) else $error("bit clock");
   a_fsync: assert property (p_fsync) else $error("frame sync");
endmodule : tlb_slot_bridge_checker
`default_nettype wire

// ### verif/tlb_local_dev.sv
// local serial device model: sends input slots, collects output frame
`timescale 1ns/1ns
`default_nettype none
module tlb_local_dev (
   input wire logic pclk,
   input wire logic local_bit_clock,
   input wire logic local_frame_sync,
   input wire logic local_serial_out,
   output logic local_serial_in,
   output logic [255:0] rx_bits
);
   logic clk_q = 1'b0;
   logic [7:0] tx;
   int idx = 0;
   initial local_serial_in = 1'b1;
   initial rx_bits = '1;
   always @(posedge pclk) begin
      clk_q <= local_bit_clock;
      if (local_bit_clock && !clk_q) begin
         idx = local_frame_sync ? (idx + 1) % 256 : 0;
         tx = idx < 40 ? 8'h11 * (idx / 8 + 3) | 8'h01 : 8'hff;
         local_serial_in <= tx[7 - idx % 8];
      end
      if (!local_bit_clock && clk_q) rx_bits[255 - idx] <= local_serial_out;
   end
endmodule : tlb_local_dev
`default_nettype wire

// ### verif/tb_tlb_slot_bridge.sv
// testbench: apb setup, backplane slot traffic and local bus checks
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb_tlb_slot_bridge;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, bp_frame_start = 1'b0, bp_slot_tick = 1'b0;
   logic [tlb_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf, bp_src_stream, bp_dst_stream;
   logic [6:0] bp_slot_num = '0, bp_dst_slot;
   logic [7:0] bp_src_byte = '0, bp_dst_byte;
   logic [7:0] bpb [32];
   logic [255:0] rx_bits;
   logic [15:0] lfsr_v = 16'h0044;
   logic pready, pslverr, bp_dst_valid, local_serial_in, local_serial_out;
   logic local_bit_clock, local_frame_sync, err, mon_on = 1'b0;
   int bad_count = 0, n_checks = 0, nvalid = 0, n0;
   tlb_slot_bridge uut (.*);
   tlb_local_dev u_dev (.pclk, .local_bit_clock, .local_frame_sync,
      .local_serial_out, .local_serial_in, .rx_bits);
   always #4 pclk = ~pclk;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic apb(input logic [17:0] a, input logic w,
         input logic [15:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 100);
      if (i >= 100) begin
         bad_count++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [17:0] a, input logic [15:0] e);
      apb(a, 1'b0, 16'h0000);
      `CHK(rd, 32'(e))
   endtask : rd_chk
   task automatic frames(input int n);
      for (int f = 0; f < n; f++) begin
         @(posedge pclk);
         bp_frame_start <= 1'b1;
         for (int s = 0; s < 32; s++) begin
            @(posedge pclk);
            bp_frame_start <= 1'b0;
            bp_slot_tick <= 1'b1;
            bp_slot_num <= 7'(s);
            bp_src_byte <= bpb[s];
            @(posedge pclk);
            bp_slot_tick <= 1'b0;
            repeat (s == 31 ? 61 : 62) @(posedge pclk);
         end
      end
   endtask : frames
   always @(posedge pclk) begin
      if (mon_on && bp_dst_valid === 1'b1) begin
         nvalid++;
         `CHK(bp_dst_stream, 4'h5)
         `CHK(bp_dst_byte, 8'h11 * (bp_dst_slot - 7'h0a + 3) | 8'h01)
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(tlb_pkg::ADDR_GLOBAL_CTRL, tlb_pkg::RST_GLOBAL_CTRL);
      rd_chk(tlb_pkg::ADDR_LOCAL_BUS_FORMAT, '0);
      rd_chk(tlb_pkg::ADDR_BACKPLANE_TO_LOCAL, '0);
      rd_chk(tlb_pkg::ADDR_LOCAL_TO_BACKPLANE, '0);
      rd_chk(18'h00010, '0);
      `CHK(err, 1'b1)
      for (int i = 0; i < 4; i++) begin
         lfsr_v = lfsr(lfsr_v);
         apb(tlb_pkg::ADDR_LOCAL_TO_BACKPLANE, 1'b1, lfsr_v);
         rd_chk(tlb_pkg::ADDR_LOCAL_TO_BACKPLANE, lfsr_v);
      end
      for (int s = 0; s < 32; s++) begin
         lfsr_v = lfsr(lfsr_v);
         bpb[s] = lfsr_v[7:0];
      end
      apb(tlb_pkg::ADDR_LOCAL_BUS_FORMAT, 1'b1, 16'h5380);
      apb(tlb_pkg::ADDR_BACKPLANE_TO_LOCAL, 1'b1, 16'h831e);
      apb(tlb_pkg::ADDR_LOCAL_TO_BACKPLANE, 1'b1, 16'h840a);
      `CHK(bp_src_stream, 4'h3)
      frames(1);
      apb(tlb_pkg::ADDR_GLOBAL_CTRL, 1'b1, 16'h0001);
      frames(1);
      mon_on = 1'b1;
      frames(3);
      `CHK(nvalid, 15)
      for (int k = 0; k < 32; k++)
         `CHK(rx_bits[255-8*k -: 8], k < 4 ? bpb[(30+k)%32] :
            8'(k < 5 ? 8'h11 * (k + 3) / 2 : 127) | 8'h80)
      apb(tlb_pkg::ADDR_BACKPLANE_TO_LOCAL, 1'b1, 16'h031e);
      frames(2);
      for (int k = 0; k < 4; k++)
         `CHK(rx_bits[255-8*k -: 8], 8'(8'h11 * (k + 3) / 2) | 8'h80)
      `CHK(nvalid, 25)
      apb(tlb_pkg::ADDR_GLOBAL_CTRL, 1'b1, 16'h0000);
      frames(1);
      n0 = nvalid;
      frames(1);
      `CHK(nvalid, n0)
      complete_run();
   end
endmodule : tb_tlb_slot_bridge
bind tlb_slot_bridge tlb_slot_bridge_checker #(.SLOT_W(SLOT_W),
   .STREAM_W(STREAM_W)) u_chk (.*);
`default_nettype wire
